// File: logic/dtv_trip_vote.sv
// divisional trip voting, bypass handling and safe-state power response
// assumes inputs from other divisions and switches are asynchronous
`timescale 1ns/1ps
`include "dtv_regs.svh"
module dtv_trip_vote #(
	parameter int DIP_CYC = `DTV_DIP_CYC,
	parameter int N_ACT = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// divisional sensor trips, one bit per division
	input wire logic [3:0] sensor_trip,
	input wire logic [3:0] trip_link_ok,
	// bypass controls
	input wire logic [3:0] div_sensor_bypass,
	input wire logic trip_logic_bypass,
	input wire logic [1:0] safety_logic_unit_fail,
	input wire logic auto_bypass_avail,
	input wire logic [1:0] manual_unit_bypass,
	// manual division trip switches, own and others
	input wire logic [3:0] manual_trip_sw,
	// interfacing system actions
	input wire logic [N_ACT-1:0] action_req,
	// health
	input wire logic power_good,
	input wire logic self_test_active,
	input wire logic fault_detect,
	// load drivers, energized means not tripped
	output logic scram_driver_energ,
	output logic isol_driver_energ,
	output logic vote_trip,
	output logic half_scram,
	output logic full_scram,
	// actuator initiation and alarms
	output logic [N_ACT-1:0] initiate,
	output logic [N_ACT-1:0] action_alarm,
	// operator indications
	output logic sensor_bypass_ind,
	output logic [1:0] unit_inop_ind,
	output logic [1:0] unit_bypass_ind,
	output logic fault_annunc,
	output logic power_loss_annunc,
	output logic link_loss_annunc
);
	// two-stage synchronisers for all pins
	localparam int SW = 4 + 4 + 4 + 1 + 2 + 1 + 2 + 4 + N_ACT + 3;
	logic [SW-1:0] sync1, sync2;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {sensor_trip, trip_link_ok, div_sensor_bypass, trip_logic_bypass,
				safety_logic_unit_fail, auto_bypass_avail, manual_unit_bypass,
				manual_trip_sw, action_req, power_good, self_test_active, fault_detect};
			sync2 <= sync1;
		end
	end
	logic [3:0] s_trip, s_link, s_byp, s_msw;
	logic s_tlb, s_auto, s_pg, s_test, s_fault;
	logic [1:0] s_fail, s_mbyp;
	logic [N_ACT-1:0] s_act;
	assign {s_trip, s_link, s_byp, s_tlb, s_fail, s_auto, s_mbyp, s_msw, s_act,
		s_pg, s_test, s_fault} = sync2;

	function automatic logic [2:0] popcnt4(input logic [3:0] v);
		popcnt4 = 3'({2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]});
	endfunction

	// vote; only one division may be bypassed, the lowest wins if several
	logic [3:0] byp_one, eff_trip;
	logic next_vote;
	always_comb begin
		byp_one = s_byp & (~s_byp + 4'h1);
		// lost link is treated as not tripped, annunciated instead
		eff_trip = s_trip & ~byp_one & s_link;
		// two of the remaining three or two of four share one threshold
		next_vote = popcnt4(eff_trip) >= 3'(`DTV_VOTE_FULL);
	end

	// power state machine: dips are bridged, long loss goes safe
	logic [31:0] dip_cnt, next_dip_cnt;
	logic [1:0] eval_cnt, next_eval_cnt;
	dtv_pkg::dtv_state_e state, next_state;
	logic latched_trip, next_latched_trip;
	always_comb begin
		next_state = state;
		next_dip_cnt = dip_cnt;
		next_eval_cnt = eval_cnt;
		next_latched_trip = latched_trip | (state == dtv_pkg::DTV_RUN && next_vote);
		if (!next_vote && state == dtv_pkg::DTV_RUN)
			next_latched_trip = 1'b0;
		case (state)
			dtv_pkg::DTV_SAFE: begin
				next_eval_cnt = 2'h0;
				if (s_pg)
					next_state = dtv_pkg::DTV_EVAL;
			end
			dtv_pkg::DTV_EVAL: begin
				// hold safe until inputs have been scanned
				if (!s_pg)
					next_state = dtv_pkg::DTV_SAFE;
				else if (eval_cnt == 2'(`DTV_EVAL_SCANS - 1))
					next_state = dtv_pkg::DTV_RUN;
				else
					next_eval_cnt = eval_cnt + 2'h1;
			end
			default: begin
				if (s_pg) begin
					next_dip_cnt = '0;
				end else if (dip_cnt >= 32'(DIP_CYC - 1)) begin
					next_state = dtv_pkg::DTV_SAFE;
					next_dip_cnt = '0;
				end else begin
					// short dip: load drivers, initiations, alarms and latched trip are frozen
					next_dip_cnt = dip_cnt + 32'h1;
					next_latched_trip = latched_trip;
				end
			end
		endcase
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= dtv_pkg::DTV_SAFE;
			dip_cnt <= '0;
			eval_cnt <= 2'h0;
			latched_trip <= 1'b0;
		end else begin
			state <= next_state;
			dip_cnt <= next_dip_cnt;
			eval_cnt <= next_eval_cnt;
			latched_trip <= next_latched_trip;
		end
	end

	// outputs; self-test input is never part of trip paths
	logic run_live, msw_any, msw_full;
	logic [1:0] unit_byp, unit_inop;
	logic next_scram, next_isol, next_half, next_full, next_vote_q, next_sbi;
	logic next_fault, next_pwr, next_link;
	logic [N_ACT-1:0] next_init, next_alarm;
	always_comb begin
		run_live = state == dtv_pkg::DTV_RUN && s_pg;
		msw_any = s_msw[0];
		msw_full = popcnt4(s_msw) >= 3'(`DTV_VOTE_FULL);
		// failed unit bypassed automatically or by hand
		unit_byp = s_fail & ({2{s_auto}} | s_mbyp);
		unit_inop = s_fail;
		next_vote_q = latched_trip;
		// trip logic bypass blocks de-energizing; manual switch does not
		next_half = msw_any | (latched_trip & ~s_tlb);
		next_full = msw_full;
		// normally energized drivers de-energize when not running
		next_scram = run_live & ~next_half & ~next_full;
		next_isol = run_live & ~(latched_trip & ~s_tlb) & ~msw_full;
		// the surviving unit carries on when one is bypassed
		next_init = (run_live && (unit_byp == unit_inop) && unit_inop != 2'h3) ? s_act : '0;
		next_alarm = next_init;
		next_sbi = |s_byp;
		next_fault = s_fault | (|unit_inop);
		next_pwr = !s_pg;
		next_link = ~&s_link;
		if (state == dtv_pkg::DTV_RUN && !s_pg) begin
			next_scram = scram_driver_energ;
			next_isol = isol_driver_energ;
			next_init = initiate;
			next_alarm = action_alarm;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			scram_driver_energ <= 1'b0;
			isol_driver_energ <= 1'b0;
			vote_trip <= 1'b0;
			half_scram <= 1'b0;
			full_scram <= 1'b0;
			initiate <= '0;
			action_alarm <= '0;
			sensor_bypass_ind <= 1'b0;
			unit_inop_ind <= 2'h0;
			unit_bypass_ind <= 2'h0;
			fault_annunc <= 1'b0;
			power_loss_annunc <= 1'b0;
			link_loss_annunc <= 1'b0;
		end else begin
			scram_driver_energ <= next_scram;
			isol_driver_energ <= next_isol;
			vote_trip <= next_vote_q;
			half_scram <= next_half;
			full_scram <= next_full;
			initiate <= next_init;
			action_alarm <= next_alarm;
			sensor_bypass_ind <= next_sbi;
			unit_inop_ind <= unit_inop;
			unit_bypass_ind <= unit_byp;
			fault_annunc <= next_fault;
			power_loss_annunc <= next_pwr;
			link_loss_annunc <= next_link;
		end
	end

	// checks
	sequence bypass_trip_s;
		(sensor_trip == 4'h3 && div_sensor_bypass == 4'h1 && trip_link_ok == 4'hf && power_good);
	endsequence
	a_bypass_excluded: assert property (@(posedge sys_clk) disable iff (rst)
		bypass_trip_s [*4] |-> ##1 !next_vote) else $error("bypassed division still votes");
	a_two_of_four: assert property (@(posedge sys_clk) disable iff (rst)
		(s_byp == 4'h0 && s_link == 4'hf && popcnt4(s_trip) >= 3'h2) |-> next_vote)
		else $error("two of four vote missed");
	a_two_of_three: assert property (@(posedge sys_clk) disable iff (rst)
		(s_byp == 4'h8 && s_link == 4'hf && s_trip[1:0] == 2'h3) |-> next_vote)
		else $error("two of three vote missed");
	a_bypass_ind: assert property (@(posedge sys_clk) disable iff (rst)
		(|s_byp) |=> sensor_bypass_ind) else $error("bypass indication missing");
	a_tlb_blocks: assert property (@(posedge sys_clk) disable iff (rst)
		(s_tlb && s_msw == 4'h0 && s_pg && state == dtv_pkg::DTV_RUN) |=> !half_scram)
		else $error("trip logic bypass did not block");
	a_manual_half: assert property (@(posedge sys_clk) disable iff (rst)
		s_msw[0] |=> half_scram && !scram_driver_energ) else $error("manual trip blocked");
	a_safe_restart: assert property (@(posedge sys_clk) disable iff (rst)
		(state != dtv_pkg::DTV_RUN) |=> !scram_driver_energ && initiate == '0)
		else $error("output left safe state before evaluation");
	a_dip_holds: assert property (@(posedge sys_clk) disable iff (rst)
		(state == dtv_pkg::DTV_RUN && !s_pg && dip_cnt < 32'(DIP_CYC - 1))
		|=> $stable(scram_driver_energ)) else $error("short dip changed output");
	a_alarm_pairs: assert property (@(posedge sys_clk) disable iff (rst)
		initiate == action_alarm) else $error("alarm not paired with initiation");
	a_unit_bypass: assert property (@(posedge sys_clk) disable iff (rst)
		(s_fail == 2'h1 && s_auto) |=> unit_bypass_ind == 2'h1)
		else $error("auto unit bypass missing");

	// unit bypass and initiation gating
	a_unit_manual: assert property (@(posedge sys_clk) disable iff (rst)
		(s_fail == 2'h1 && !s_auto && s_mbyp == 2'h1) |=> unit_bypass_ind == 2'h1)
		else $error("manual unit bypass missing");
	a_unit_inop: assert property (@(posedge sys_clk) disable iff (rst)
		(s_fail != 2'h0) |=> unit_inop_ind == $past(s_fail))
		else $error("unit inoperative not shown");
	a_init_follows: assert property (@(posedge sys_clk) disable iff (rst)
		(run_live && s_fail == 2'h1 && s_auto) |=> initiate == $past(s_act))
		else $error("surviving unit did not carry on");
	a_init_blocked: assert property (@(posedge sys_clk) disable iff (rst)
		(s_fail == 2'h3 && s_pg) |=> initiate == '0 && action_alarm == '0)
		else $error("initiation with both units failed");

	// self-test stays off the trip paths
	a_test_no_fake: assert property (@(posedge sys_clk) disable iff (rst)
		(run_live && s_test && !latched_trip && s_msw == 4'h0) |=> scram_driver_energ)
		else $error("self-test caused a trip");
	a_test_no_mask: assert property (@(posedge sys_clk) disable iff (rst)
		(s_pg && s_test && latched_trip && !s_tlb) |=> half_scram && !scram_driver_energ)
		else $error("self-test masked a trip");

	// annunciation follows its cause one scan later
	a_power_annunc: assert property (@(posedge sys_clk) disable iff (rst)
		!s_pg |=> power_loss_annunc)
		else $error("power loss not annunciated");
	a_link_annunc: assert property (@(posedge sys_clk) disable iff (rst)
		(s_link != 4'hf) |=> link_loss_annunc)
		else $error("trip link loss not annunciated");
	a_fault_annunc: assert property (@(posedge sys_clk) disable iff (rst)
		s_fault |=> fault_annunc)
		else $error("fault not annunciated");
	a_lost_link_vote: assert property (@(posedge sys_clk) disable iff (rst)
		(s_link == 4'hc && s_byp == 4'h0 && s_trip == 4'h3) |-> !next_vote)
		else $error("lost link produced a trip");
	a_manual_full: assert property (@(posedge sys_clk) disable iff (rst)
		(popcnt4(s_msw) >= 3'h2) |=> full_scram)
		else $error("two manual switches gave no full scram");

	// long loss forces the safe state, restart waits out the scans
	a_long_loss_safe: assert property (@(posedge sys_clk) disable iff (rst)
		(state == dtv_pkg::DTV_RUN && !s_pg && dip_cnt >= 32'(DIP_CYC - 1)) |=> ##1
		(!scram_driver_energ && !isol_driver_energ && initiate == '0)) else $error("long loss not safe");
	sequence restart_s;
		(state == dtv_pkg::DTV_SAFE && s_pg) ##1 (state == dtv_pkg::DTV_EVAL && s_pg);
	endsequence
	a_eval_hold: assert property (@(posedge sys_clk) disable iff (rst)
		restart_s |=> state == dtv_pkg::DTV_EVAL && !scram_driver_energ)
		else $error("restart skipped evaluation");
endmodule

// File: logic/dtv_regs.svh
// constants for the divisional trip voting block
// assumes a 20 MHz sys_clk; include by bare name
`ifndef DTV_REGS_SVH
`define DTV_REGS_SVH
`define DTV_NUM_DIV 4
`define DTV_CLK_HZ 20000000
// power dip that must ride through, in ms
`define DTV_DIP_MS 1000
// dip ride-through count in cycles (exceeds 4096: top parameter default)
`define DTV_DIP_CYC ((`DTV_CLK_HZ / 1000) * `DTV_DIP_MS)
// evaluation scans required before outputs leave the safe state
`define DTV_EVAL_SCANS 2
`define DTV_VOTE_FULL 2
`endif

// File: logic/dtv_pkg.sv
// types for the divisional trip voting block
// no surroundings assumed
package dtv_pkg;
	typedef enum logic [1:0] {
		DTV_SAFE,
		DTV_EVAL,
		DTV_RUN
	} dtv_state_e;
endpackage

// File: test/dtv_act_model.sv
// scram actuator stand-in driven by the divisional load driver
// assumes the drive level comes straight from the design output
`timescale 1ns/1ps
module dtv_act_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// from load driver
	input wire logic drive_energ,
	// actuator state
	output logic rods_in
);
	logic next_rods_in;
	// solenoid drops out one cycle after the driver lets go
	always_comb begin
		next_rods_in = ~drive_energ;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// driver is de-energized in reset, so rods count as in
			rods_in <= 1'b1;
		end else begin
			rods_in <= next_rods_in;
		end
	end
endmodule

// File: test/dtv_tb.sv
// self-checking bench for the divisional trip voting block
// assumes dtv_trip_vote and dtv_act_model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] sensor_trip = 4'h0, trip_link_ok = 4'hf, div_sensor_bypass = 4'h0;
	logic [3:0] manual_trip_sw = 4'h0, action_req = 4'h1;
	logic trip_logic_bypass = 1'b0, auto_bypass_avail = 1'b1, power_good = 1'b1;
	logic self_test_active = 1'b0, fault_detect = 1'b0;
	logic [1:0] safety_logic_unit_fail = 2'h0, manual_unit_bypass = 2'h0;
	logic scram_driver_energ, half_scram, full_scram, sensor_bypass_ind, fault_annunc;
	logic link_loss_annunc, rods_in, isol_driver_energ, vote_trip, power_loss_annunc;
	logic [3:0] initiate, action_alarm;
	logic [1:0] unit_inop_ind, unit_bypass_ind;
	logic [41:0] q[$];
	localparam logic [20:0] all_bits = 21'h1fffff;
	int errors = 0, num_checks = 0, cyc = 0;
	event smp;
	wire [20:0] obs = {rods_in, half_scram, full_scram, sensor_bypass_ind, link_loss_annunc,
		fault_annunc, isol_driver_energ, vote_trip, power_loss_annunc, unit_inop_ind,
		unit_bypass_ind, initiate, action_alarm};
	// short dip count keeps the ride-through test brief
	dtv_trip_vote #(.DIP_CYC(20), .N_ACT(4)) u_dut (.sys_clk, .rst, .sensor_trip, .trip_link_ok,
		.div_sensor_bypass, .trip_logic_bypass, .safety_logic_unit_fail, .auto_bypass_avail,
		.manual_unit_bypass, .manual_trip_sw, .action_req, .power_good, .self_test_active,
		.fault_detect, .scram_driver_energ, .isol_driver_energ, .vote_trip, .half_scram,
		.full_scram, .initiate, .action_alarm, .sensor_bypass_ind, .unit_inop_ind,
		.unit_bypass_ind, .fault_annunc, .power_loss_annunc, .link_loss_annunc);
	dtv_act_model u_act (.sys_clk, .rst, .drive_energ(scram_driver_energ), .rods_in);
	always #25 sys_clk = ~sys_clk;
	// safe: outputs expected in the safe state after a long power loss
	function automatic logic [20:0] calc(input logic safe);
		logic [3:0] v, act;
		logic [1:0] fl, byp;
		logic t, h, f;
		v = sensor_trip & trip_link_ok & ~div_sensor_bypass;
		fl = safety_logic_unit_fail;
		t = $countones(v) >= 2;
		// only the own division's switch gives a half-scram
		h = (t & ~trip_logic_bypass) | manual_trip_sw[0];
		f = $countones(manual_trip_sw) >= 2;
		byp = auto_bypass_avail ? fl : fl & manual_unit_bypass;
		act = (!safe && !(&fl) && fl == byp) ? action_req : 4'h0;
		calc = {h | f | safe, h, f, |div_sensor_bypass, ~&trip_link_ok, fault_detect | (|fl),
			~((t & ~trip_logic_bypass) | f | safe), t, ~power_good, fl, byp, act, act};
	endfunction
	task automatic note(input logic [20:0] m, input logic [20:0] e);
		q.push_back({m, e});
		repeat (10) @(posedge sys_clk);
		#2 -> smp;
	endtask
	task automatic apply(input logic [23:0] w);
		@(posedge sys_clk);
		#2;
		{sensor_trip, div_sensor_bypass, manual_trip_sw, trip_link_ok, safety_logic_unit_fail,
			auto_bypass_avail, manual_unit_bypass, trip_logic_bypass, self_test_active,
			fault_detect} = w;
		note(all_bits, calc(1'b0));
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(smp) begin
		logic [41:0] e;
		e = q.pop_front();
		`CHK("outputs", e[20:0] & e[41:21], obs & e[41:21])
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		logic [23:0] rows [15];
		rows = '{24'h300f20, 24'h100f20, 24'h320f20, 24'h520f20, 24'h300f24,
			24'h001f24, 24'h003f20, 24'h300f22, 24'h000f22, 24'h300c20,
			24'h000f60, 24'h000f40, 24'h000f48, 24'h000f21, 24'h000fe0};
		void'($urandom(24445));
		repeat (10) @(posedge sys_clk);
		#2 rst = 1'b0;
		repeat (12) @(posedge sys_clk);
		foreach (rows[i]) apply(rows[i]);
		// random trips and actions exercise the plain two-of-four vote
		repeat (10) begin
			action_req = 4'($urandom);
			apply({4'($urandom), 12'h00f, 8'h20});
		end
		apply(24'h300f20);
		// short dips, looked at mid-dip: a trip is kept, an idle division stays energized
		power_good = 1'b0;
		note(all_bits, calc(1'b0));
		power_good = 1'b1;
		note(all_bits, calc(1'b0));
		apply(24'h000f20);
		power_good = 1'b0;
		note(all_bits, calc(1'b0));
		repeat (30) @(posedge sys_clk);
		note(all_bits, calc(1'b1));
		power_good = 1'b1;
		note(all_bits, calc(1'b0));
		wrap_up();
	end
endmodule
